//--- verilog/mcs_sequencer.sv
// Measurement sequencer: contact checking, contact improvement and
// self-calibration scheduling, with an Avalon-MM register slave.
// Assumes pins measure_request, cal_request, contact_over_a/b and
// low_power_strap are asynchronous; all else runs on clk.
//
// How it works
// - Watch both drive-to-pickup pairs in measurement; error over threshold.
// - Separate error flags for side one and side two.
// - No comparator judgment while a contact error stands.
// - Range of 100 Mohm or more keeps contact checking on, except in two-wire mode.
// - Two-wire multiplexer mode forces contact checking off.
// - Free-running trigger stops measurement current on contact error.
// - Contact check default is off in low power, else on.
// - Optional improvement phase drives pickup current before measuring.
// - Improvement phase adds exactly 0.2 ms.
// - Low-power mode forces contact improvement off.
// - Measurement held 5 ms per auto and 400 ms per manual calibration.
// - Auto mode calibrates right after each measurement, within 5 ms.
// - Auto mode holds one request during post-measurement calibration.
// - Auto mode calibrates 5 ms once per second while idle.
// - Request during idle calibration aborts it; measure 0.5 ms later.
// - During a scan, post-measurement calibration waits until the scan ends.
// - Manual-to-auto switch runs 400 ms calibration; controller stays quiet.
// - Manual mode calibrates at once on calibration request.
// - Manual request during calibration held, done dropped, measure after.
// - Manual calibration request during measurement queued until it ends.
`timescale 1ns/1ps
module mcs_sequencer #(
  parameter int unsigned CAL_AUTO_CYC =
    mcs_pkg::CAL_AUTO_US * (mcs_pkg::CLK_KHZ / 1000),
  parameter int unsigned CAL_LONG_CYC =
    mcs_pkg::CAL_MANUAL_MS * mcs_pkg::CLK_KHZ,
  parameter int unsigned IDLE_CAL_CYC =
    mcs_pkg::IDLE_CAL_MS * mcs_pkg::CLK_KHZ,
  parameter int unsigned ABORT_CYC =
    mcs_pkg::ABORT_DELAY_US * (mcs_pkg::CLK_KHZ / 1000),
  parameter int unsigned IMPROVE_CYC =
    mcs_pkg::IMPROVE_US * (mcs_pkg::CLK_KHZ / 1000)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        measure_request,
  input  wire logic        cal_request,
  input  wire logic        contact_over_a,
  input  wire logic        contact_over_b,
  input  wire logic        low_power_strap,
  output logic             measure_done_flag,
  output logic             meas_current_en,
  output logic             improve_drive,
  output logic             cal_busy,
  output logic             contact_err_a,
  output logic             contact_err_b,
  output logic             judge_enable
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n_s;
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic       measure_request_prev_reg;
  logic       calreq_prev_reg;
  logic       measure_request_pulse;
  logic       calreq_pulse;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_reg[1];

  // Raw reset here, so the strap has settled when the internal reset lifts
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_reg      <= 5'h00;
      pin_s2_reg      <= 5'h00;
      measure_request_prev_reg   <= 1'b0;
      calreq_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg      <= {low_power_strap, contact_over_b, contact_over_a,
                          cal_request, measure_request};
      pin_s2_reg      <= pin_s1_reg;
      measure_request_prev_reg   <= pin_s2_reg[0];
      calreq_prev_reg <= pin_s2_reg[1];
    end
  end
  assign measure_request_pulse   = pin_s2_reg[0] & ~measure_request_prev_reg;
  assign calreq_pulse = pin_s2_reg[1] & ~calreq_prev_reg;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_reg;
  logic [31:0] meas_len_reg;
  logic        ack_reg;
  logic        strap_done_reg;
  logic [31:0] status_word;
  logic        chk_on;
  logic        imp_on;
  logic        auto_mode;

  mcs_pkg::mcs_state_t    state_reg;
  mcs_pkg::mcs_cal_kind_t kind_reg;
  logic measure_request_pend_reg;
  logic cal_pend_reg;

  // Fixed two-cycle access: request cycle, then answer cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl_reg       <= mcs_pkg::CTRL_RESET;
      meas_len_reg   <= 32'(mcs_pkg::MEAS_LEN_DEFAULT);
      ack_reg        <= 1'b0;
      avs_readdata   <= 32'h0000_0000;
      strap_done_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (!strap_done_reg) begin
        strap_done_reg <= 1'b1;
        ctrl_reg[mcs_pkg::CTRL_LOW_POWER]  <= pin_s2_reg[4];
        ctrl_reg[mcs_pkg::CTRL_CONTACT_EN] <= ~pin_s2_reg[4];
      end else if (avs_write && ack_reg) begin
        // Write lands on the edge that sees waitrequest low
        if (avs_address == mcs_pkg::ADDR_CTRL) begin
          ctrl_reg <= avs_writedata[7:0];
        end else if (avs_address == mcs_pkg::ADDR_MEAS_LEN) begin
          // Zero would stall the counter, so it is held at one
          meas_len_reg <= (avs_writedata == 32'h0000_0000) ?
                          32'h0000_0001 : avs_writedata;
        end
      end
      if (avs_read && !ack_reg) begin
        case (avs_address)
          mcs_pkg::ADDR_CTRL:     avs_readdata <= {24'h000000, ctrl_reg};
          mcs_pkg::ADDR_STATUS:   avs_readdata <= status_word;
          mcs_pkg::ADDR_MEAS_LEN: avs_readdata <= meas_len_reg;
          default:                avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign status_word = {21'h000000, 3'(state_reg), 3'h0, cal_pend_reg,
                        measure_request_pend_reg, measure_done_flag,
                        contact_err_b, contact_err_a};

  assign chk_on = (ctrl_reg[mcs_pkg::CTRL_CONTACT_EN] |
                   ctrl_reg[mcs_pkg::CTRL_RANGE_HIGH]) &
                  ~ctrl_reg[mcs_pkg::CTRL_TWO_WIRE];
  assign imp_on = ctrl_reg[mcs_pkg::CTRL_IMPROVE_EN] &
                  ~ctrl_reg[mcs_pkg::CTRL_LOW_POWER];
  assign auto_mode = ctrl_reg[mcs_pkg::CTRL_CAL_AUTO];

  // ----------------------------------------------------------------
  // Measurement and calibration sequencing
  // ----------------------------------------------------------------
  logic [31:0] cnt_reg;
  logic [31:0] idle_cnt_reg;
  logic        scan_defer_reg;
  logic        auto_prev_reg;
  logic        auto_switch_reg;
  logic        cnt_end;
  logic        meas_start;

  assign cnt_end    = (cnt_reg == 32'h0000_0001);
  assign meas_start = (state_reg != mcs_pkg::MCS_MEASURE) &&
                      (state_reg != mcs_pkg::MCS_IMPROVE);

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      auto_prev_reg   <= 1'b0;
      auto_switch_reg <= 1'b0;
    end else begin
      auto_prev_reg <= auto_mode & strap_done_reg;
      // switch seen; a new switch wins over consumption
      if (auto_mode && strap_done_reg && !auto_prev_reg) begin
        auto_switch_reg <= 1'b1;
      end else if (state_reg == mcs_pkg::MCS_IDLE) begin
        auto_switch_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_reg         <= mcs_pkg::MCS_IDLE;
      kind_reg          <= mcs_pkg::MCS_CAL_POST;
      cnt_reg           <= 32'h0000_0001;
      idle_cnt_reg      <= 32'h0000_0000;
      measure_request_pend_reg     <= 1'b0;
      cal_pend_reg      <= 1'b0;
      scan_defer_reg    <= 1'b0;
      measure_done_flag <= 1'b0;
      judge_enable      <= 1'b0;
    end else begin
      judge_enable <= 1'b0;
      cnt_reg      <= cnt_reg - 32'h0000_0001;
      // Idle count restarts after any exit from idle
      idle_cnt_reg <= 32'h0000_0000;
      case (state_reg)
        mcs_pkg::MCS_IDLE: begin
          idle_cnt_reg <= auto_mode ? idle_cnt_reg + 32'h0000_0001 :
                          32'h0000_0000;
          if (measure_request_pulse) begin
            measure_done_flag <= 1'b0;
            idle_cnt_reg      <= 32'h0000_0000;
            state_reg <= imp_on ? mcs_pkg::MCS_IMPROVE :
                         mcs_pkg::MCS_MEASURE;
            cnt_reg   <= imp_on ? 32'(IMPROVE_CYC) : meas_len_reg;
          end else if (auto_switch_reg) begin
            state_reg <= mcs_pkg::MCS_CAL;
            kind_reg  <= mcs_pkg::MCS_CAL_LONG;
            cnt_reg   <= 32'(CAL_LONG_CYC);
          end else if (!auto_mode && (calreq_pulse || cal_pend_reg)) begin
            state_reg    <= mcs_pkg::MCS_CAL;
            kind_reg     <= mcs_pkg::MCS_CAL_LONG;
            cnt_reg      <= 32'(CAL_LONG_CYC);
            cal_pend_reg <= 1'b0;
          end else if (auto_mode && scan_defer_reg &&
                       !ctrl_reg[mcs_pkg::CTRL_SCAN_BUSY]) begin
            state_reg      <= mcs_pkg::MCS_CAL;
            kind_reg       <= mcs_pkg::MCS_CAL_POST;
            cnt_reg        <= 32'(CAL_AUTO_CYC);
            scan_defer_reg <= 1'b0;
          end else if (auto_mode && idle_cnt_reg >= 32'(IDLE_CAL_CYC)) begin
            state_reg    <= mcs_pkg::MCS_CAL;
            kind_reg     <= mcs_pkg::MCS_CAL_IDLE;
            cnt_reg      <= 32'(CAL_AUTO_CYC);
            idle_cnt_reg <= 32'h0000_0000;
          end
        end
        mcs_pkg::MCS_IMPROVE: begin
          if (cnt_end) begin
            state_reg <= mcs_pkg::MCS_MEASURE;
            cnt_reg   <= meas_len_reg;
          end
        end
        mcs_pkg::MCS_MEASURE: begin
          if (!auto_mode && calreq_pulse) begin
            cal_pend_reg <= 1'b1;
          end
          if (cnt_end) begin
            measure_done_flag <= 1'b1;
            // judge only clean results, last sample included
            judge_enable <= ~(contact_err_a | contact_err_b |
                              (chk_on & (pin_s2_reg[2] | pin_s2_reg[3])));
            if (!auto_mode && (cal_pend_reg || calreq_pulse)) begin
              state_reg    <= mcs_pkg::MCS_CAL;
              kind_reg     <= mcs_pkg::MCS_CAL_LONG;
              cnt_reg      <= 32'(CAL_LONG_CYC);
              cal_pend_reg <= 1'b0;
            end else if (auto_mode &&
                         !ctrl_reg[mcs_pkg::CTRL_SCAN_BUSY]) begin
              state_reg <= mcs_pkg::MCS_CAL;
              kind_reg  <= mcs_pkg::MCS_CAL_POST;
              cnt_reg   <= 32'(CAL_AUTO_CYC);
            end else begin
              scan_defer_reg <= auto_mode;
              state_reg      <= mcs_pkg::MCS_IDLE;
            end
          end
        end
        mcs_pkg::MCS_CAL: begin
          if (measure_request_pulse && kind_reg == mcs_pkg::MCS_CAL_IDLE) begin
            state_reg         <= mcs_pkg::MCS_DELAY;
            cnt_reg           <= 32'(ABORT_CYC);
            measure_done_flag <= 1'b0;
          end else if (cnt_end) begin
            if (measure_request_pend_reg || measure_request_pulse) begin
              measure_request_pend_reg <= 1'b0;
              measure_done_flag <= 1'b0;
              state_reg <= imp_on ? mcs_pkg::MCS_IMPROVE :
                           mcs_pkg::MCS_MEASURE;
              cnt_reg   <= imp_on ? 32'(IMPROVE_CYC) : meas_len_reg;
            end else begin
              state_reg <= mcs_pkg::MCS_IDLE;
            end
          end else if (measure_request_pulse) begin
            measure_request_pend_reg     <= 1'b1;
            measure_done_flag <= 1'b0;
          end
        end
        mcs_pkg::MCS_DELAY: begin
          if (cnt_end) begin
            state_reg <= imp_on ? mcs_pkg::MCS_IMPROVE :
                         mcs_pkg::MCS_MEASURE;
            cnt_reg   <= imp_on ? 32'(IMPROVE_CYC) : meas_len_reg;
          end
        end
        default: begin
          state_reg <= mcs_pkg::MCS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Contact monitoring
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      contact_err_a <= 1'b0;
      contact_err_b <= 1'b0;
    end else if (!chk_on) begin
      contact_err_a <= 1'b0;
      contact_err_b <= 1'b0;
    end else if (state_reg == mcs_pkg::MCS_IMPROVE ||
                 state_reg == mcs_pkg::MCS_MEASURE) begin
      contact_err_a <= contact_err_a | pin_s2_reg[2];
      contact_err_b <= contact_err_b | pin_s2_reg[3];
    end else if (meas_start) begin
      contact_err_a <= pin_s2_reg[2];
      contact_err_b <= pin_s2_reg[3];
    end
  end

  // cut current on error when free-running
  assign meas_current_en = (state_reg == mcs_pkg::MCS_MEASURE) &
                           ~(ctrl_reg[mcs_pkg::CTRL_FREE_RUN] &
                             (contact_err_a | contact_err_b));
  assign improve_drive   = (state_reg == mcs_pkg::MCS_IMPROVE);
  assign cal_busy        = (state_reg == mcs_pkg::MCS_CAL);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_two_wire_off;
    @(posedge clk) disable iff (!rst_n_s)
    ctrl_reg[mcs_pkg::CTRL_TWO_WIRE] |=> !contact_err_a && !contact_err_b;
  endproperty
  a_two_wire_off: assert property (p_two_wire_off)
    else $error("contact error with two-wire mode");

  property p_judge_clean;
    @(posedge clk) disable iff (!rst_n_s)
    judge_enable |-> !contact_err_a && !contact_err_b;
  endproperty
  a_judge_clean: assert property (p_judge_clean)
    else $error("judgment given with contact error");

  property p_free_run_cut;
    @(posedge clk) disable iff (!rst_n_s)
    ctrl_reg[mcs_pkg::CTRL_FREE_RUN] && (contact_err_a || contact_err_b)
      |-> !meas_current_en;
  endproperty
  a_free_run_cut: assert property (p_free_run_cut)
    else $error("current on during contact error");

  property p_err_a_sets;
    @(posedge clk) disable iff (!rst_n_s)
    chk_on && $past(chk_on) && state_reg == mcs_pkg::MCS_MEASURE &&
      $past(state_reg) == mcs_pkg::MCS_MEASURE && $past(pin_s2_reg[2])
      |-> contact_err_a;
  endproperty
  a_err_a_sets: assert property (p_err_a_sets)
    else $error("pair A fault missed");

  property p_low_power_no_improve;
    @(posedge clk) disable iff (!rst_n_s)
    ctrl_reg[mcs_pkg::CTRL_LOW_POWER] && state_reg == mcs_pkg::MCS_IDLE
      |=> !improve_drive;
  endproperty
  a_low_power_no_improve: assert property (p_low_power_no_improve)
    else $error("improvement in low power");

  property p_improve_to_measure;
    @(posedge clk) disable iff (!rst_n_s)
    $fell(improve_drive) |-> state_reg == mcs_pkg::MCS_MEASURE;
  endproperty
  a_improve_to_measure: assert property (p_improve_to_measure)
    else $error("improvement not followed by measurement");

  property p_done_after_measure;
    @(posedge clk) disable iff (!rst_n_s)
    $rose(measure_done_flag) |->
      $past(state_reg) == mcs_pkg::MCS_MEASURE;
  endproperty
  a_done_after_measure: assert property (p_done_after_measure)
    else $error("done rose outside measurement");

  property p_measure_request_in_cal_held;
    @(posedge clk) disable iff (!rst_n_s)
    cal_busy && measure_request_pulse && kind_reg != mcs_pkg::MCS_CAL_IDLE && !cnt_end
      |=> measure_request_pend_reg && !measure_done_flag && cal_busy;
  endproperty
  a_measure_request_in_cal_held: assert property (p_measure_request_in_cal_held)
    else $error("request during calibration lost");

  property p_idle_abort;
    @(posedge clk) disable iff (!rst_n_s)
    cal_busy && measure_request_pulse && kind_reg == mcs_pkg::MCS_CAL_IDLE
      |=> state_reg == mcs_pkg::MCS_DELAY && cnt_reg == 32'(ABORT_CYC);
  endproperty
  a_idle_abort: assert property (p_idle_abort)
    else $error("idle calibration not aborted");

endmodule : mcs_sequencer

//--- verilog/mcs_pkg.sv
// Constants for the contact check and self-calibration sequencer.
// Assumes a single 250 MHz measurement clock; timing counts derive
// from the printed times in the sequencer's parameter defaults.
package mcs_pkg;

  // ----------------------------------------------------------------
  // Clock and printed times
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ          = 250000;
  localparam int unsigned CAL_AUTO_US      = 5000;
  localparam int unsigned CAL_MANUAL_MS    = 400;
  localparam int unsigned IDLE_CAL_MS      = 1000;
  localparam int unsigned ABORT_DELAY_US   = 500;
  localparam int unsigned IMPROVE_US       = 200;
  localparam int unsigned MEAS_LEN_DEFAULT = 1000;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_MEAS_LEN = 4'h8;

  // Control register fields
  localparam int CTRL_CONTACT_EN = 0;
  localparam int CTRL_IMPROVE_EN = 1;
  localparam int CTRL_LOW_POWER  = 2;
  localparam int CTRL_CAL_AUTO   = 3;
  localparam int CTRL_RANGE_HIGH = 4;
  localparam int CTRL_TWO_WIRE   = 5;
  localparam int CTRL_FREE_RUN   = 6;
  localparam int CTRL_SCAN_BUSY  = 7;
  localparam int CTRL_WIDTH      = 8;
  localparam logic [7:0] CTRL_RESET = 8'h01;

  // Status register fields
  localparam int STAT_ERR_A     = 0;
  localparam int STAT_ERR_B     = 1;
  localparam int STAT_DONE      = 2;
  localparam int STAT_MEASURE_REQUEST_PEND = 3;
  localparam int STAT_CAL_PEND  = 4;
  localparam int STAT_STATE_LSB = 8;

  typedef enum {
    MCS_IDLE,
    MCS_IMPROVE,
    MCS_MEASURE,
    MCS_CAL,
    MCS_DELAY
  } mcs_state_t;

  typedef enum {
    MCS_CAL_POST,
    MCS_CAL_IDLE,
    MCS_CAL_LONG
  } mcs_cal_kind_t;

endpackage : mcs_pkg

//--- testbench/mcs_ctrl_model.sv
// External controller model: measure and calibration request pins.
// Assumes callers leave at least 8 clk between two requests.
`timescale 1ns/1ps
module mcs_ctrl_model (
  input  wire logic clk,
  output logic      measure_request,
  output logic      cal_request
);
  initial begin
    measure_request = 1'b0;
    cal_request     = 1'b0;
  end
  // ----------------------------------------------------------------
  // Request pulses
  // ----------------------------------------------------------------
  // requests only on command
  // Held 4 clk so the 3-stage edge detect sees it
  task automatic pulse(input bit cal);
    if (cal) begin
      cal_request <= 1'b1;
    end else begin
      measure_request <= 1'b1;
    end
    fork
      begin
        repeat (4) @(posedge clk);
        cal_request     <= 1'b0;
        measure_request <= 1'b0;
      end
    join_none
  endtask : pulse
endmodule : mcs_ctrl_model

//--- testbench/mcs_sequencer_tb.sv
// Self-checking bench for the measurement sequencer.
// Assumes shortened calibration counts and a 30-cycle measurement.
`timescale 1ns/1ps
module mcs_sequencer_tb;
  localparam int ML = 30;
  localparam int CL = 200;
  localparam int CA = 50;
  localparam int IC = 500;
  localparam int AB = 20;
  localparam int IM = 10;
  logic        clk;
  logic        rstn;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        mreq;
  logic        creq;
  logic        over_a;
  logic        over_b;
  logic        strap;
  logic        done;
  logic        cur;
  logic        imp;
  logic        busy;
  logic        err_a;
  logic        err_b;
  logic        judge;
  logic [31:0] q;
  int          n;
  int          n_errors;
  int          samples_checked;
  int          n_judge;
  int          n_imp;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  mcs_ctrl_model u_ctrl (.clk(clk), .measure_request(mreq),
    .cal_request(creq));

  mcs_sequencer #(.CAL_AUTO_CYC(CA), .CAL_LONG_CYC(CL),
    .IDLE_CAL_CYC(IC), .ABORT_CYC(AB), .IMPROVE_CYC(IM)) u_dut (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .measure_request(mreq),
    .cal_request(creq), .contact_over_a(over_a),
    .contact_over_b(over_b), .low_power_strap(strap),
    .measure_done_flag(done), .meas_current_en(cur),
    .improve_drive(imp), .cal_busy(busy), .contact_err_a(err_a),
    .contact_err_b(err_b), .judge_enable(judge));

  always @(posedge clk) begin
    if (judge === 1'b1) n_judge++;
    if (imp === 1'b1) n_imp++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic sig(input int k);
    case (k)
      0: return cur;
      1: return imp;
      2: return busy;
      default: return done;
    endcase
  endfunction : sig

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic wait_v(input int k, input bit v, output int c);
    c = 0;
    while (sig(k) !== v && c < 3000) begin
      @(posedge clk);
      c++;
    end
    if (c >= 3000) begin
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
    end
  endtask : wait_v

  task automatic len(input int k, output int c);
    int t;
    wait_v(k, 1'b1, t);
    c = 0;
    while (sig(k) === 1'b1 && c < 3000) begin
      c++;
      @(posedge clk);
    end
  endtask : len

  // Avalon master: hold until waitrequest sampled low
  task automatic bus(input bit w, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !w;
    avs_write     <= w;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic meas_end(input int ej, input int el);
    int j0;
    j0 = n_judge;
    len(0, n);
    chk(n, el);
    repeat (2) @(posedge clk);
    chk(done, 1'b1);
    chk(n_judge - j0, ej);
  endtask : meas_end

  task automatic meas(input int ej);
    repeat (4) @(posedge clk);
    u_ctrl.pulse(1'b0);
    meas_end(ej, ML);
  endtask : meas

  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, avs_read, avs_write, over_a, over_b, strap} = '0;
    avs_address   = 4'h0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    bus(0, mcs_pkg::ADDR_CTRL, 0); chk(q, 32'h01);
    bus(0, mcs_pkg::ADDR_MEAS_LEN, 0); chk(q, 32'h3E8);
    bus(0, 4'hC, 0); chk(q, 32'h0);
    bus(1, mcs_pkg::ADDR_MEAS_LEN, ML);
    over_a <= 1'b1;
    meas(0); chk({err_b, err_a}, 2'b01);
    over_a <= 1'b0;
    over_b <= 1'b1;
    meas(0); chk({err_b, err_a}, 2'b10);
    bus(1, mcs_pkg::ADDR_CTRL, 32'h21);
    meas(1); chk(err_b, 1'b0);
    bus(1, mcs_pkg::ADDR_CTRL, 32'h10);
    meas(0); chk(err_b, 1'b1);
    bus(1, mcs_pkg::ADDR_CTRL, 32'h41);
    u_ctrl.pulse(1'b0);
    repeat (12) @(posedge clk);
    chk(cur, 1'b0);
    chk(done, 1'b0);
    wait_v(3, 1'b1, n);
    over_b <= 1'b0;
    for (int lp = 0; lp < 2; lp++) begin
      bus(1, mcs_pkg::ADDR_CTRL, 32'h03 | (lp << 2));
      n_imp = 0;
      meas(1); chk(n_imp, lp ? 0 : IM);
    end
    bus(1, mcs_pkg::ADDR_CTRL, 32'h01);
    u_ctrl.pulse(1'b1);
    len(2, n); chk(n, CL);
    u_ctrl.pulse(1'b1);
    repeat (20) @(posedge clk);
    u_ctrl.pulse(1'b0);
    repeat (8) @(posedge clk);
    chk({busy, done}, 2'b10);
    bus(0, mcs_pkg::ADDR_STATUS, 0); chk(q, 32'h308);
    wait_v(2, 1'b0, n);
    meas_end(1, ML);
    u_ctrl.pulse(1'b0);
    repeat (8) @(posedge clk);
    u_ctrl.pulse(1'b1);
    // Length counted from 4 cycles into the running measurement
    meas_end(1, ML - 4); chk(busy, 1'b1);
    wait_v(2, 1'b0, n);
    bus(1, mcs_pkg::ADDR_CTRL, 32'h09);
    len(2, n); chk(n, CL);
    u_ctrl.pulse(1'b0);
    len(0, n);
    repeat (10) @(posedge clk);
    u_ctrl.pulse(1'b0);
    len(2, n);
    len(0, n); chk(n, ML);
    len(2, n); chk(n, CA);
    bus(1, mcs_pkg::ADDR_CTRL, 32'h89);
    u_ctrl.pulse(1'b0);
    len(0, n);
    repeat (60) @(posedge clk);
    chk(busy, 1'b0);
    bus(1, mcs_pkg::ADDR_CTRL, 32'h09);
    len(2, n); chk(n, CA);
    wait_v(2, 1'b1, n); chk(n > IC - 20 && n <= IC + 10, 1);
    len(2, n); chk(n, CA);
    wait_v(2, 1'b1, n);
    repeat (10) @(posedge clk);
    u_ctrl.pulse(1'b0);
    wait_v(2, 1'b0, n); chk(n < 8, 1);
    wait_v(0, 1'b1, n); chk(n >= AB - 2 && n <= AB + 4, 1);
    // Mid-run reset with the low-power strap high
    rstn   <= 1'b0;
    strap  <= 1'b1;
    over_a <= 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
    bus(0, mcs_pkg::ADDR_CTRL, 0); chk(q, 32'h04);
    bus(1, mcs_pkg::ADDR_MEAS_LEN, ML);
    meas(1); chk(err_a, 1'b0);
    end_of_test();
  end
endmodule : mcs_sequencer_tb
